// File: shared/cbt_pkg.sv
// Constants and types shared by the CAN bit timing logic
package cbt_pkg;

    // Bus levels
    localparam logic RECESSIVE = 1'b1;
    localparam logic DOMINANT  = 1'b0;

    // Field widths
    localparam int PRESCALE_W = 6;
    localparam int SEG_W      = 3;
    localparam int JUMP_W     = 2;
    localparam int TQ_CNT_W   = 4;
    localparam int QUANTA_W   = 5;
    localparam int BIT_CYC_W  = 12;

    // Processing time after the sample point, in quanta
    localparam logic [TQ_CNT_W-1:0] PROC_TIME_TQ = 4'h2;

    // Rate ceiling: shortest nominal bit and the clock period, in ns
    localparam int MIN_BIT_NS  = 1000;
    localparam int CLK_PERIOD_NS = 25;
    localparam int MIN_BIT_CYC_I = (MIN_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [BIT_CYC_W-1:0] MIN_BIT_CYC = MIN_BIT_CYC_I[BIT_CYC_W-1:0];

    // Reset values
    localparam logic [PRESCALE_W-1:0] PRESCALE_RST = 6'h00;
    localparam logic [TQ_CNT_W-1:0]   TQ_CNT_RST   = 4'h0;
    localparam logic [2:0]            RX_SYNC_RST  = 3'h7;
    localparam logic [1:0]            HIST_RST     = 2'h3;

    // Segment of the bit period, Gray coded along the bit
    typedef enum logic [1:0] {
        SEG_SYNC  = 2'h0,
        SEG_PROP  = 2'h1,
        SEG_PHASE1 = 2'h3,
        SEG_PHASE2 = 2'h2
    } cbt_seg_t;

    // Timing configuration; length fields hold length minus one
    typedef struct packed {
        logic [PRESCALE_W-1:0] quantum_prescale_field;
        logic [JUMP_W-1:0]     jump_width_field;
        logic [SEG_W-1:0]      propagation_length_field;
        logic [SEG_W-1:0]      first_phase_length_field;
        logic [SEG_W-1:0]      second_phase_length_field;
        logic                  triple_sample_select;
        logic                  second_phase_source_select;
    } cbt_cfg_t;

    // Per-bit timing events
    typedef struct packed {
        logic     quantum_tick;
        logic     sample_point;
        logic     bit_start;
        logic     hard_sync;
        logic     resync;
        cbt_seg_t segment;
    } cbt_evt_t;

endpackage

// File: src/cbt_bit_timing.sv
// Bit timing phase loop: quanta, segments, sampling and resynchronisation
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Nominal bit rate ceiling is 1 Mb/s; a faster setting is flagged.
// - Each bit is sync, propagation, first phase, second phase in order.
// - Total bit period programmable from five to twenty-five quanta.
// - One quantum lasts two times prescale-plus-one clock periods.
// - Prescale is the unsigned six-bit configuration field.
// - Sync part is one quantum; edges are expected inside it.
// - Propagation part is one to eight quanta from its field.
// - First phase is one to eight quanta; sample taken at its end.
// - Second phase one to eight quanta, never effectively below two.
// - Second phase may be the larger of first phase and processing time.
// - Resync lengthens first phase or shortens second phase.
// - Triple sampling takes majority of three samples half a quantum apart.
// - NRZ line; timing is recovered from data edges.
// - Stuffed edges at least every six bits keep the loop locked.
// - Same loop times received bits and transmitted bits.
// - Source select set uses second phase field, clear uses the larger rule.
// - Triple select set votes three samples, clear takes one.
// - Falling edge while bus idle hard-syncs, restarting at sync part.
// - Resync adjustment limited by jump width of one to four quanta.
module cbt_bit_timing (
    input  wire logic             i_clk,
    input  wire logic             i_sys_rst,
    input  wire logic             i_can_rx,
    input  wire cbt_pkg::cbt_cfg_t i_cfg,
    input  wire logic             i_bus_idle,
    input  wire logic             i_tx_bit,
    output logic                  o_can_tx,
    output logic                  o_rx_bit,
    output cbt_pkg::cbt_evt_t     o_evt,
    output logic [cbt_pkg::QUANTA_W-1:0] o_bit_quanta,
    output logic                  o_rate_over_limit
);

    typedef struct packed {
        logic [2:0]                          rx_sync;
        logic                                rx_filt;
        logic [cbt_pkg::PRESCALE_W-1:0]      presc_cnt;
        logic                                half;
        cbt_pkg::cbt_seg_t                   seg;
        logic [cbt_pkg::TQ_CNT_W-1:0]        tq_cnt;
        logic [cbt_pkg::TQ_CNT_W-1:0]        ph1_ext;
        logic [cbt_pkg::TQ_CNT_W-1:0]        ph2_cut;
        logic                                synced;
        logic [1:0]                          hist;
        logic                                rx_bit;
        logic                                tx_out;
        logic                                tx_dom;
        cbt_pkg::cbt_evt_t                   evt;
    } cbt_state_t;

    cbt_state_t st_reg;
    cbt_state_t st_next;

    logic [cbt_pkg::TQ_CNT_W-1:0] prop_len;
    logic [cbt_pkg::TQ_CNT_W-1:0] ph1_len;
    logic [cbt_pkg::TQ_CNT_W-1:0] ph2_field_len;
    logic [cbt_pkg::TQ_CNT_W-1:0] ph2_base;
    logic [cbt_pkg::TQ_CNT_W-1:0] ph1_eff;
    logic [cbt_pkg::TQ_CNT_W-1:0] ph2_eff;
    logic [cbt_pkg::TQ_CNT_W-1:0] jump_len;
    logic [cbt_pkg::QUANTA_W-1:0] pos_err;
    logic [cbt_pkg::TQ_CNT_W-1:0] neg_err;
    logic [cbt_pkg::BIT_CYC_W-1:0] bit_cycles;
    logic                          half_tick;
    logic                          tq_tick;
    logic                          fall_edge;
    logic                          vote;

    always_comb begin
        prop_len      = {1'b0, i_cfg.propagation_length_field} + 4'h1;
        ph1_len       = {1'b0, i_cfg.first_phase_length_field} + 4'h1;
        ph2_field_len = {1'b0, i_cfg.second_phase_length_field} + 4'h1;
        jump_len      = {2'h0, i_cfg.jump_width_field} + 4'h1;
        // Explicit field or larger of first phase and processing time
        if (i_cfg.second_phase_source_select) begin
            ph2_base = ph2_field_len;
        end else begin
            ph2_base = (ph1_len > cbt_pkg::PROC_TIME_TQ) ? ph1_len
                                                        : cbt_pkg::PROC_TIME_TQ;
        end
        if (ph2_base < cbt_pkg::PROC_TIME_TQ) begin
            ph2_base = cbt_pkg::PROC_TIME_TQ;
        end
        ph1_eff = ph1_len + st_reg.ph1_ext;
        ph2_eff = ph2_base - st_reg.ph2_cut;
        o_bit_quanta = 5'h01 + {1'b0, prop_len} + {1'b0, ph1_len}
                     + {1'b0, ph2_base};
        bit_cycles = 12'(o_bit_quanta) * ({5'h00, i_cfg.quantum_prescale_field, 1'b0} + 12'h002);
        o_rate_over_limit = (bit_cycles < cbt_pkg::MIN_BIT_CYC);
    end

    // Half quantum every prescale+1 clocks, quantum every second half
    assign half_tick = (st_reg.presc_cnt == i_cfg.quantum_prescale_field);
    assign tq_tick   = half_tick && st_reg.half;

    // Recessive to dominant once the two later stages agree
    assign fall_edge = (st_reg.rx_sync[2] == st_reg.rx_sync[1])
                    && (st_reg.rx_filt == cbt_pkg::RECESSIVE)
                    && (st_reg.rx_sync[2] == cbt_pkg::DOMINANT);

    assign pos_err = (st_reg.seg == cbt_pkg::SEG_PROP)
                   ? {1'b0, st_reg.tq_cnt} + 5'h01
                   : {1'b0, prop_len} + {1'b0, st_reg.tq_cnt} + 5'h01;
    assign neg_err = ph2_eff - st_reg.tq_cnt;

    // Majority of sample point and the two half-quantum earlier samples
    assign vote = (st_reg.rx_filt & st_reg.hist[0]) | (st_reg.rx_filt & st_reg.hist[1])
                | (st_reg.hist[0] & st_reg.hist[1]);

    always_comb begin
        st_next = st_reg;
        st_next.evt.quantum_tick = 1'b0;
        st_next.evt.sample_point = 1'b0;
        st_next.evt.bit_start    = 1'b0;
        st_next.evt.hard_sync    = 1'b0;
        st_next.evt.resync       = 1'b0;

        st_next.rx_sync = {st_reg.rx_sync[1:0], i_can_rx};
        if (st_reg.rx_sync[2] == st_reg.rx_sync[1]) begin
            st_next.rx_filt = st_reg.rx_sync[2];
        end

        if (half_tick) begin
            st_next.presc_cnt = '0;
            st_next.half      = ~st_reg.half;
            st_next.hist      = {st_reg.hist[0], st_reg.rx_filt};
        end else begin
            st_next.presc_cnt = st_reg.presc_cnt + 6'h01;
        end

        if (tq_tick) begin
            st_next.evt.quantum_tick = 1'b1;
            st_next.tq_cnt = st_reg.tq_cnt + 4'h1;
            unique case (st_reg.seg)
                cbt_pkg::SEG_SYNC: begin
                    st_next.seg    = cbt_pkg::SEG_PROP;
                    st_next.tq_cnt = cbt_pkg::TQ_CNT_RST;
                end
                cbt_pkg::SEG_PROP: begin
                    if (st_reg.tq_cnt == prop_len - 4'h1) begin
                        st_next.seg    = cbt_pkg::SEG_PHASE1;
                        st_next.tq_cnt = cbt_pkg::TQ_CNT_RST;
                    end
                end
                cbt_pkg::SEG_PHASE1: begin
                    if (st_reg.tq_cnt == ph1_eff - 4'h1) begin
                        st_next.seg    = cbt_pkg::SEG_PHASE2;
                        st_next.tq_cnt = cbt_pkg::TQ_CNT_RST;
                        st_next.evt.sample_point = 1'b1;
                        st_next.rx_bit = i_cfg.triple_sample_select ? vote
                                                                    : st_reg.rx_filt;
                    end
                end
                cbt_pkg::SEG_PHASE2: begin
                    // A cut may land below the count already reached
                    if (st_reg.tq_cnt >= ph2_eff - 4'h1) begin
                        st_next.seg     = cbt_pkg::SEG_SYNC;
                        st_next.tq_cnt  = cbt_pkg::TQ_CNT_RST;
                        st_next.ph1_ext = '0;
                        st_next.ph2_cut = '0;
                        st_next.synced  = 1'b0;
                        st_next.evt.bit_start = 1'b1;
                        st_next.tx_out  = i_tx_bit;
                        st_next.tx_dom  = (i_tx_bit == cbt_pkg::DOMINANT);
                    end
                end
            endcase
        end

        // Edge handling overrides the quantum step; at most once per bit
        if (fall_edge && !st_reg.synced && st_reg.rx_bit == cbt_pkg::RECESSIVE) begin
            st_next.synced = 1'b1;
            if (i_bus_idle) begin
                st_next.evt.hard_sync = 1'b1;
                st_next.seg       = cbt_pkg::SEG_SYNC;
                st_next.tq_cnt    = cbt_pkg::TQ_CNT_RST;
                st_next.presc_cnt = cbt_pkg::PRESCALE_RST;
                st_next.half      = 1'b0;
                st_next.ph1_ext   = '0;
                st_next.ph2_cut   = '0;
                // Restarted bit: no sample and no bit start this quantum
                st_next.evt.sample_point = 1'b0;
                st_next.evt.bit_start    = 1'b0;
                st_next.rx_bit    = st_reg.rx_bit;
            end else begin
                unique case (st_reg.seg)
                    cbt_pkg::SEG_SYNC: begin
                        st_next.synced = 1'b1;
                    end
                    cbt_pkg::SEG_PROP, cbt_pkg::SEG_PHASE1: begin
                        // Transmitter of a dominant bit skips late-phase edges
                        if (!st_reg.tx_dom) begin
                            st_next.evt.resync = 1'b1;
                            if (pos_err <= {1'b0, jump_len}) begin
                                st_next.seg       = cbt_pkg::SEG_SYNC;
                                st_next.tq_cnt    = cbt_pkg::TQ_CNT_RST;
                                st_next.presc_cnt = cbt_pkg::PRESCALE_RST;
                                st_next.half      = 1'b0;
                                // Bit restarted, so no sample this quantum
                                st_next.evt.sample_point = 1'b0;
                                st_next.rx_bit    = st_reg.rx_bit;
                            end else begin
                                st_next.ph1_ext = jump_len;
                            end
                        end
                    end
                    cbt_pkg::SEG_PHASE2: begin
                        st_next.evt.resync = 1'b1;
                        if (neg_err <= jump_len) begin
                            st_next.seg       = cbt_pkg::SEG_SYNC;
                            st_next.tq_cnt    = cbt_pkg::TQ_CNT_RST;
                            st_next.presc_cnt = cbt_pkg::PRESCALE_RST;
                            st_next.half      = 1'b0;
                            st_next.ph1_ext   = '0;
                            st_next.ph2_cut   = '0;
                            st_next.evt.bit_start = 1'b1;
                            st_next.tx_out    = i_tx_bit;
                            st_next.tx_dom    = (i_tx_bit == cbt_pkg::DOMINANT);
                        end else begin
                            st_next.ph2_cut = jump_len;
                        end
                    end
                endcase
            end
        end
        st_next.evt.segment = st_next.seg;
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_reg.rx_sync   <= cbt_pkg::RX_SYNC_RST;
            st_reg.rx_filt   <= cbt_pkg::RECESSIVE;
            st_reg.presc_cnt <= cbt_pkg::PRESCALE_RST;
            st_reg.half      <= 1'b0;
            st_reg.seg       <= cbt_pkg::SEG_SYNC;
            st_reg.tq_cnt    <= cbt_pkg::TQ_CNT_RST;
            st_reg.ph1_ext   <= '0;
            st_reg.ph2_cut   <= '0;
            st_reg.synced    <= 1'b0;
            st_reg.hist      <= cbt_pkg::HIST_RST;
            st_reg.rx_bit    <= cbt_pkg::RECESSIVE;
            st_reg.tx_out    <= cbt_pkg::RECESSIVE;
            st_reg.tx_dom    <= 1'b0;
            st_reg.evt       <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_can_tx = st_reg.tx_out;
    assign o_rx_bit = st_reg.rx_bit;
    assign o_evt    = st_reg.evt;

endmodule
`default_nettype wire

// File: verif/cbt_checker.sv
// Assertions on the bit timing ports
`timescale 1ns/100ps
`default_nettype none
module cbt_checker (
    input wire logic                         i_clk,
    input wire logic                         i_sys_rst,
    input wire logic                         i_can_rx,
    input wire cbt_pkg::cbt_cfg_t            i_cfg,
    input wire logic                         i_bus_idle,
    input wire logic                         i_tx_bit,
    input wire logic                         o_can_tx,
    input wire logic                         o_rx_bit,
    input wire cbt_pkg::cbt_evt_t            o_evt,
    input wire logic [cbt_pkg::QUANTA_W-1:0] o_bit_quanta,
    input wire logic                         o_rate_over_limit
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    logic [7:0] gap_reg;
    logic       dirty_reg;
    logic       sync_d_reg;
    logic [4:0] ph2;
    logic [4:0] quanta;
    wire logic  sync_ev = o_evt.hard_sync | o_evt.resync;
    always_comb begin
        ph2 = 5'h1 + 5'(i_cfg.second_phase_source_select ? i_cfg.second_phase_length_field
                                                         : i_cfg.first_phase_length_field);
        if (ph2 < 5'h2)
            ph2 = 5'h2;
        quanta = 5'h3 + 5'(i_cfg.propagation_length_field) + 5'(i_cfg.first_phase_length_field) + ph2;
    end
    // Clocks between quantum ticks; intervals touched by a sync are skipped
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            gap_reg    <= 8'h0;
            dirty_reg  <= 1'b1;
            sync_d_reg <= 1'b0;
        end else begin
            sync_d_reg <= sync_ev;
            gap_reg    <= o_evt.quantum_tick ? 8'h1 : gap_reg + 8'h1;
            dirty_reg  <= sync_ev | sync_d_reg | (dirty_reg & ~o_evt.quantum_tick);
        end
    end
    bit_quanta_a: assert property (
        o_bit_quanta == quanta)
        else $error("bit length wrong");
    rate_flag_a: assert property (
        o_rate_over_limit == (int'(quanta) * 2 * (int'(i_cfg.quantum_prescale_field) + 1)
        < cbt_pkg::MIN_BIT_CYC_I))
        else $error("rate flag wrong");
    quantum_len_a: assert property (
        o_evt.quantum_tick && !dirty_reg && !sync_ev
        |-> int'(gap_reg) == 2 * (int'(i_cfg.quantum_prescale_field) + 1))
        else $error("quantum length wrong");
    seg_order_a: assert property (
        $changed(o_evt.segment) |-> o_evt.segment == cbt_pkg::SEG_SYNC
        || ($past(o_evt.segment) == cbt_pkg::SEG_SYNC && o_evt.segment == cbt_pkg::SEG_PROP)
        || ($past(o_evt.segment) == cbt_pkg::SEG_PROP && o_evt.segment == cbt_pkg::SEG_PHASE1)
        || ($past(o_evt.segment) == cbt_pkg::SEG_PHASE1 && o_evt.segment == cbt_pkg::SEG_PHASE2))
        else $error("segment order wrong");
    sample_place_a: assert property (
        o_evt.sample_point |-> o_evt.segment == cbt_pkg::SEG_PHASE2
        && $past(o_evt.segment) == cbt_pkg::SEG_PHASE1)
        else $error("sample point misplaced");
    bit_wrap_a: assert property (
        o_evt.bit_start |-> o_evt.segment == cbt_pkg::SEG_SYNC
        && $past(o_evt.segment) == cbt_pkg::SEG_PHASE2)
        else $error("bit start misplaced");
    tx_change_a: assert property (
        $changed(o_can_tx) |-> o_evt.segment == cbt_pkg::SEG_SYNC)
        else $error("transmit changed off bit start");
    tx_follow_a: assert property (
        o_evt.bit_start |-> o_can_tx == $past(i_tx_bit))
        else $error("transmit level not taken at bit start");
    rx_change_a: assert property (
        $changed(o_rx_bit) |-> o_evt.sample_point)
        else $error("receive changed off sample point");
    hard_sync_a: assert property (
        o_evt.hard_sync |-> $past(i_bus_idle) && !o_evt.bit_start
        && o_evt.segment == cbt_pkg::SEG_SYNC)
        else $error("hard sync wrong");
    cover property (o_evt.resync);
    cover property (o_evt.hard_sync);
    cover property (o_evt.sample_point && i_cfg.triple_sample_select);
    cover property (o_evt.resync && $past(o_evt.segment) == cbt_pkg::SEG_PHASE2);
endmodule
bind cbt_bit_timing cbt_checker cbt_checker_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_can_rx(i_can_rx), .i_cfg(i_cfg), .i_bus_idle(i_bus_idle), .i_tx_bit(i_tx_bit),
    .o_can_tx(o_can_tx), .o_rx_bit(o_rx_bit), .o_evt(o_evt), .o_bit_quanta(o_bit_quanta),
    .o_rate_over_limit(o_rate_over_limit));
`default_nettype wire

// File: verif/cbt_bus_node.sv
// Remote CAN node sharing the bus line with the block
`timescale 1ns/100ps
`default_nettype none
module cbt_bus_node (
    input  wire logic i_clk,
    input  wire logic i_dut_tx,
    output wire logic o_bus
);
    logic node_tx = 1'b1;
    assign o_bus = node_tx & i_dut_tx; // Wired-AND, dominant wins
    // NRZ frame, MSB first; callers pass frames with an edge every few bits
    task automatic send(input logic [15:0] frame, input int period);
        for (int i = 15; i >= 0; i--) begin
            node_tx = frame[i];
            repeat (period) @(negedge i_clk);
        end
        node_tx = 1'b1;
    endtask
endmodule
`default_nettype wire

// File: verif/tb.sv
// Self-checking bench for the CAN bit timing logic
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic              i_clk;
    logic              i_sys_rst;
    logic              i_bus_idle;
    logic              i_tx_bit;
    cbt_pkg::cbt_cfg_t i_cfg;
    cbt_pkg::cbt_cfg_t c;
    cbt_pkg::cbt_evt_t o_evt;
    wire logic         bus;
    logic              o_can_tx;
    logic              o_rx_bit;
    logic [4:0]        o_bit_quanta;
    logic              o_rate_over_limit;
    logic [31:0]       lfsr = 32'h004975a8;
    logic [15:0]       got;
    logic              t;
    int                n_fail = 0;
    int                n_checks = 0;
    int                cycles = 0;
    int                n_resync = 0;
    int                n;
    int                m;
    int                tq;
    int                sp;
    cbt_bit_timing cbt_bit_timing_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_can_rx(bus),
        .i_cfg(i_cfg), .i_bus_idle(i_bus_idle), .i_tx_bit(i_tx_bit), .o_can_tx(o_can_tx),
        .o_rx_bit(o_rx_bit), .o_evt(o_evt), .o_bit_quanta(o_bit_quanta),
        .o_rate_over_limit(o_rate_over_limit));
    cbt_bus_node cbt_bus_node_inst (.i_clk(i_clk), .i_dut_tx(o_can_tx), .o_bus(bus));
    function automatic logic [4:0] exp_quanta(input cbt_pkg::cbt_cfg_t k);
        logic [4:0] p2;
        p2 = 5'h1 + 5'(k.second_phase_source_select ? k.second_phase_length_field
                                                     : k.first_phase_length_field);
        if (p2 < 5'h2)
            p2 = 5'h2;
        return 5'h3 + 5'(k.propagation_length_field) + 5'(k.first_phase_length_field) + p2;
    endfunction
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Falling edges until the chosen pulse: 0 bit start, 1 sample point, 2 hard sync
    task automatic wait_evt(input int which, output int cnt);
        logic ev;
        cnt = 0;
        do begin
            @(negedge i_clk);
            cnt++;
            ev = which == 0 ? o_evt.bit_start : which == 1 ? o_evt.sample_point : o_evt.hard_sync;
        end while (ev !== 1'b1 && cnt < 5000);
        if (ev !== 1'b1)
            n_fail++;
    endtask
    task automatic restart();
        i_cfg = c;
        i_sys_rst = 1'b1;
        repeat (5) @(negedge i_clk);
        i_sys_rst = 1'b0;
    endtask
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 40000) begin
            n_fail++;
            summarize();
        end
    end
    always @(negedge i_clk) begin
        if (o_evt.resync === 1'b1)
            n_resync++;
    end
    initial begin
        {i_bus_idle, i_tx_bit} = 2'b01;
        c = '0;
        // Timing of quanta, sample point and bit length over random and corner settings
        for (int k = 0; k < 10; k++) begin
            lfsr = lfsr_next(lfsr);
            c = cbt_pkg::cbt_cfg_t'(lfsr[18:0]);
            c.quantum_prescale_field = {4'h0, lfsr[20:19]};
            c.propagation_length_field[2] = 1'b1; // Every bit nine quanta or more
            if (k == 0)
                c = '{6'h00, 2'h0, 3'h4, 3'h0, 3'h0, 1'b0, 1'b0};
            if (k == 1)
                c = '{6'h3f, 2'h3, 3'h7, 3'h7, 3'h7, 1'b1, 1'b1};
            if (k == 2)
                c = '{6'h01, 2'h0, 3'h4, 3'h5, 3'h0, 1'b0, 1'b1};
            restart();
            tq = 2 * (int'(c.quantum_prescale_field) + 1);
            sp = 3 + c.propagation_length_field + c.first_phase_length_field;
            check(o_bit_quanta, exp_quanta(c));
            check(o_rate_over_limit, int'(exp_quanta(c)) * tq < 40);
            wait_evt(0, n);
            for (int b = 0; b < 3; b++) begin
                t = lfsr[b];
                i_tx_bit = t;
                wait_evt(1, n);
                check(n, sp * tq);
                check(o_rx_bit, o_can_tx);
                wait_evt(0, m);
                check(n + m, exp_quanta(c) * tq);
                check(o_can_tx, t);
            end
            $display("timing config %0d done", k);
        end
        // Reception from a slower and a faster node: hard sync, both resyncs, both modes
        for (int s = 0; s < 3; s++) begin
            c = '{6'h01, 2'h3, 3'h3, 3'h3, 3'h3, s[0], 1'b1};
            restart();
            {i_bus_idle, i_tx_bit} = 2'b11;
            repeat (20) @(negedge i_clk);
            m = n_resync;
            fork
                cbt_bus_node_inst.send(16'h3b4d, 54 - 3 * s[1]);
                begin
                    wait_evt(2, n);
                    i_bus_idle = 1'b0;
                    for (int b = 15; b >= 0; b--) begin
                        wait_evt(1, n);
                        got[b] = o_rx_bit;
                    end
                end
            join
            check(got, 16'h3b4d);
            check(n_resync > m, 1'b1);
            $display("reception mode %0d done", s);
        end
        summarize();
    end
endmodule
`default_nettype wire
